// File: design/lpbpa_partner_ability.sv
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
// Behaviour
// R1: Reading the low partner register copies live partner bits 47:16 into the middle and upper registers.
// R2: Middle and upper registers return the last snapshot, never the live page.
// R3: Both partner snapshot registers clear to zero on reset.
// R4: Middle bit 14 shows partner 10BASE-T1L ability.
// R5: Middle bit 7 shows partner 1000BASE-T1 ability.
// R6: Middle bit 6 shows partner 10BASE-T1S full duplex ability.
// R7: Middle bit 5 shows partner 100BASE-T1 ability.
// R8: Middle bit 4 shows partner role, 0 slave and 1 master.
// R9: The role bit comes from bit 4 of the partner nonce field.
// R10: Software treats the role bit as preference or forced per the force flag.
// R11: Upper bit 14 shows partner energy efficient Ethernet ability.
// R12: Upper bit 13 shows partner ability to transmit at 2.4 V p-p.
// R13: Upper bit 12 shows partner request for the high transmit level.
// R14: Upper bit 11 shows partner 10BASE-T1S half duplex ability.
// R15: Force flag reads 0 for a preferred role and 1 for a forced role.
// R16: Low level if either lacks high ability, else high if either requests it.
// R17: All partner fields are read-only; reserved bits read zero; writes change nothing.
module lpbpa_partner_ability #(
    parameter int ADDR_W = 12
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output wire logic                      s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output wire logic                      s_axi_wready,
    output wire logic [1:0]                s_axi_bresp,
    output wire logic                      s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [ADDR_W-1:0]         s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output wire logic                      s_axi_arready,
    output wire logic [31:0]               s_axi_rdata,
    output wire logic [1:0]                s_axi_rresp,
    output wire logic                      s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire lpbpa_pkg::lpbpa_rx_page_s rxPage,
    output wire logic                      txHighLevel
);
    import lpbpa_pkg::*;

    lpbpa_wr_req_s wrReq;
    lpbpa_rd_req_s rdReq;
    logic          wrHit;
    logic          rdHit;
    logic [31:0]   rdData;

    logic [15:0]   partnerMid_reg;
    logic [15:0]   partnerHigh_reg;
    logic [15:0]   localHigh_reg;
    logic [15:0]   localHigh_next;
    logic          snapTaken_reg;
    logic          txHighLevel_reg;
    logic          txHighLevel_next;

    logic [15:0]   liveLow;
    logic [15:0]   liveMid;
    logic [15:0]   liveHigh;
    logic [15:0]   statusWord;

    wire           lowRead;
    wire           localWrite;
    wire           selLocal;
    wire           selLow;
    wire           selMid;
    wire           selHigh;
    wire           selStatus;
    wire           wrSelLocal;
    wire           wrSelPartner;
    wire           wrSelStatus;
    wire           localAble;
    wire           localRequest;

    lpbpa_axil_slave #(
        .ADDR_W (ADDR_W)
    ) u_bus (
        .clk           (clk),
        .rst           (rst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wrReq         (wrReq),
        .wrHit         (wrHit),
        .rdReq         (rdReq),
        .rdData        (rdData),
        .rdHit         (rdHit)
    );

    // Live partner page laid out as the three register words
    always_comb begin
        liveLow                                 = 16'h0000;
        liveLow[LOW_NEXT_PAGE_BIT]              = rxPage.nextPage;
        liveLow[LOW_ACK_BIT]                    = rxPage.ack;
        liveLow[LOW_FAULT_BIT]                  = rxPage.remoteFault;
        liveLow[LOW_FORCE_BIT]                  = rxPage.roleForced;  // [R15]
        liveLow[LOW_PAUSE_LSB+1:LOW_PAUSE_LSB]  = rxPage.pause;
        liveLow[4:0]                            = rxPage.selector;
    end

    always_comb begin
        liveMid                   = 16'h0000;  // [R17]
        liveMid[MID_T1L_BIT]      = rxPage.t1lAble;  // [R4]
        liveMid[MID_GIG_BIT]      = rxPage.gigT1Able;  // [R5]
        liveMid[MID_T1S_FULL_BIT] = rxPage.t1sFullAble;  // [R6]
        liveMid[MID_FAST_BIT]     = rxPage.fastT1Able;  // [R7]
        // Role is not a page field of its own but a bit of the nonce
        liveMid[MID_MASTER_BIT]   = rxPage.nonce[NONCE_ROLE_BIT];  // [R8] [R9]
    end

    always_comb begin
        liveHigh                    = 16'h0000;  // [R17]
        liveHigh[HIGH_EEE_BIT]      = rxPage.energySavingAble;  // [R11]
        liveHigh[HIGH_LVL_ABLE_BIT] = rxPage.highLevelAble;  // [R12]
        liveHigh[HIGH_LVL_REQ_BIT]  = rxPage.highLevelRequest;  // [R13]
        liveHigh[HIGH_T1S_HALF_BIT] = rxPage.t1sHalfAble;  // [R14]
    end

    // Read decode
    assign selLocal  = rdReq.idx == IDX_LOCAL_HIGH;
    assign selLow    = rdReq.idx == IDX_PARTNER_LOW;
    assign selMid    = rdReq.idx == IDX_PARTNER_MID;
    assign selHigh   = rdReq.idx == IDX_PARTNER_HIGH;
    assign selStatus = rdReq.idx == IDX_LINK_STATUS;
    assign rdHit     = selLocal | selLow | selMid | selHigh | selStatus;
    assign lowRead   = rdReq.en & selLow;

    always_comb begin
        statusWord                  = 16'h0000;
        statusWord[STATUS_HIGH_BIT] = txHighLevel_reg;
        statusWord[STATUS_SNAP_BIT] = snapTaken_reg;
    end

    // Middle and upper words come from the snapshot only
    assign rdData = {16'h0000,
                     ({16{selLocal}}  & localHigh_reg)
                   | ({16{selLow}}    & liveLow)
                   | ({16{selMid}}    & partnerMid_reg)  // [R2]
                   | ({16{selHigh}}   & partnerHigh_reg)  // [R2]
                   | ({16{selStatus}} & statusWord)};

    // Write decode; writes to read-only words are accepted and dropped
    assign wrSelLocal   = wrReq.idx == IDX_LOCAL_HIGH;
    assign wrSelPartner = wrReq.idx == IDX_PARTNER_LOW
                        | wrReq.idx == IDX_PARTNER_MID
                        | wrReq.idx == IDX_PARTNER_HIGH;  // [R17]
    assign wrSelStatus  = wrReq.idx == IDX_LINK_STATUS;
    assign wrHit        = wrSelLocal | wrSelPartner | wrSelStatus;
    assign localWrite   = wrReq.en & wrSelLocal & wrReq.strb[1];

    // Only the two level bits sit in byte lane 1; all other local bits read zero
    assign localHigh_next = localWrite ? (wrReq.data[15:0] & LOCAL_HIGH_WR_MASK)
                                       : localHigh_reg;

    // Level resolution uses the live page so it tracks renegotiation
    assign localAble        = localHigh_reg[HIGH_LVL_ABLE_BIT];
    assign localRequest     = localHigh_reg[HIGH_LVL_REQ_BIT];
    assign txHighLevel_next = localAble & rxPage.highLevelAble
                            & (localRequest | rxPage.highLevelRequest);  // [R16]
    assign txHighLevel      = txHighLevel_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            partnerMid_reg  <= PARTNER_MID_RESET;  // [R3]
            partnerHigh_reg <= PARTNER_HIGH_RESET;  // [R3]
        end else if (lowRead) begin
            partnerMid_reg  <= liveMid;  // [R1]
            partnerHigh_reg <= liveHigh;  // [R1]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            localHigh_reg   <= LOCAL_HIGH_RESET;
            snapTaken_reg   <= 1'b0;
            txHighLevel_reg <= 1'b0;
        end else begin
            localHigh_reg   <= localHigh_next;
            snapTaken_reg   <= snapTaken_reg | lowRead;
            txHighLevel_reg <= txHighLevel_next;  // [R16]
        end
    end

    default clocking cbM @(posedge clk); endclocking
    default disable iff (rst);

    sequence seqLowRead;
        rdReq.en && rdReq.idx == IDX_PARTNER_LOW;
    endsequence

    sequence seqPartnerWrite;
        wrReq.en && wrSelPartner;
    endsequence

    sequence seqNoLowRead2;
        !(rdReq.en && selLow) [*2];
    endsequence

    AST_SNAP_ON_LOW_READ: assert property ( // [R1]
        seqLowRead |=> partnerMid_reg == $past(liveMid)
                    && partnerHigh_reg == $past(liveHigh))
        else $error("snapshot not taken on low register read");

    AST_SNAP_HOLDS: assert property ( // [R2]
        seqLowRead ##1 seqNoLowRead2
        |-> $stable(partnerMid_reg) && $stable(partnerHigh_reg))
        else $error("snapshot moved without a low register read");

    AST_READ_SNAPSHOT: assert property ( // [R2]
        !lowRead |=> $stable(partnerMid_reg) && $stable(partnerHigh_reg))
        else $error("partner snapshot followed the live page");

    AST_MID_RETURNS_SNAPSHOT: assert property ( // [R2]
        rdReq.en && (selMid || selHigh)
        |=> s_axi_rvalid
            && s_axi_rdata[15:0] == $past(selMid ? partnerMid_reg : partnerHigh_reg)
            && s_axi_rdata[31:16] == 16'h0000)
        else $error("partner word read did not return the snapshot");

    AST_RESET_CLEAR: assert property ( // [R3]
        $fell(rst) |-> partnerMid_reg == 16'h0000 && partnerHigh_reg == 16'h0000)
        else $error("partner words not zero after reset");

    AST_MID_FIELDS: assert property ( // [R4] [R5] [R6] [R7] [R8] [R9]
        seqLowRead |=> partnerMid_reg[14] == $past(rxPage.t1lAble)
                    && partnerMid_reg[7] == $past(rxPage.gigT1Able)
                    && partnerMid_reg[6] == $past(rxPage.t1sFullAble)
                    && partnerMid_reg[5] == $past(rxPage.fastT1Able)
                    && partnerMid_reg[4] == $past(rxPage.nonce[4]))
        else $error("middle word field misplaced");

    AST_HIGH_FIELDS: assert property ( // [R11] [R12] [R13] [R14]
        seqLowRead |=> partnerHigh_reg[14] == $past(rxPage.energySavingAble)
                    && partnerHigh_reg[13] == $past(rxPage.highLevelAble)
                    && partnerHigh_reg[12] == $past(rxPage.highLevelRequest)
                    && partnerHigh_reg[11] == $past(rxPage.t1sHalfAble))
        else $error("upper word field misplaced");

    AST_FORCE_FLAG: assert property ( // [R15]
        seqLowRead |=> s_axi_rdata[12] == $past(rxPage.roleForced))
        else $error("force flag read wrong");

    AST_TX_LEVEL: assert property ( // [R16]
        ##1 txHighLevel == ($past(localAble) && $past(rxPage.highLevelAble)
                            && ($past(localRequest) || $past(rxPage.highLevelRequest))))
        else $error("transmit level resolved wrongly");

    AST_RESERVED_ZERO: assert property ( // [R17]
        (partnerMid_reg & 16'hBF0F) == 16'h0000
        && (partnerHigh_reg & 16'h87FF) == 16'h0000)
        else $error("reserved partner bit set");

    AST_WRITE_IGNORED: assert property ( // [R17]
        seqPartnerWrite and !(rdReq.en && selLow)
        |=> $stable(partnerMid_reg) && $stable(partnerHigh_reg) && s_axi_bvalid)
        else $error("write altered a read-only partner word");

    sequence seqLevelBlocked;
        !localAble || !rxPage.highLevelAble;
    endsequence

    sequence seqLevelAsked;
        localAble && rxPage.highLevelAble && (localRequest || rxPage.highLevelRequest);
    endsequence

    AST_TX_LOW_WHEN_UNABLE: assert property ( // [R16]
        seqLevelBlocked |=> !txHighLevel)
        else $error("high level used although one side lacks it");

    AST_TX_HIGH_ON_REQUEST: assert property ( // [R16]
        seqLevelAsked |=> txHighLevel)
        else $error("high level not used although requested");

    AST_SNAP_FLAG: assert property ( // [R1]
        lowRead |=> snapTaken_reg)
        else $error("snapshot flag not set by low register read");

    AST_UPPER_HALF_ZERO: assert property ( // [R17]
        rdReq.en |=> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper half of a register word not zero");

    AST_UNMAPPED_READ: assert property ( // [R17]
        rdReq.en && !rdHit |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");

endmodule : lpbpa_partner_ability

// File: design/lpbpa_pkg.sv
package lpbpa_pkg;

    localparam int REG_IDX_W = 10;
    typedef logic [REG_IDX_W-1:0] lpbpa_idx_t;

    // Register indices; byte address is four times the index
    localparam lpbpa_idx_t IDX_LOCAL_HIGH   = 10'h204;
    localparam lpbpa_idx_t IDX_PARTNER_LOW  = 10'h205;
    localparam lpbpa_idx_t IDX_PARTNER_MID  = 10'h206;
    localparam lpbpa_idx_t IDX_PARTNER_HIGH = 10'h207;
    localparam lpbpa_idx_t IDX_LINK_STATUS  = 10'h210;

    localparam logic [15:0] PARTNER_MID_RESET  = 16'h0000;
    localparam logic [15:0] PARTNER_HIGH_RESET = 16'h0000;
    localparam logic [15:0] LOCAL_HIGH_RESET   = 16'h0000;
    localparam logic [15:0] LOCAL_HIGH_WR_MASK = 16'h3000;

    // Field positions in the partner and local registers
    localparam int MID_T1L_BIT       = 14;
    localparam int MID_GIG_BIT       = 7;
    localparam int MID_T1S_FULL_BIT  = 6;
    localparam int MID_FAST_BIT      = 5;
    localparam int MID_MASTER_BIT    = 4;
    localparam int NONCE_ROLE_BIT    = 4;
    localparam int HIGH_EEE_BIT      = 14;
    localparam int HIGH_LVL_ABLE_BIT = 13;
    localparam int HIGH_LVL_REQ_BIT  = 12;
    localparam int HIGH_T1S_HALF_BIT = 11;
    localparam int LOW_NEXT_PAGE_BIT = 15;
    localparam int LOW_ACK_BIT       = 14;
    localparam int LOW_FAULT_BIT     = 13;
    localparam int LOW_FORCE_BIT     = 12;
    localparam int LOW_PAUSE_LSB     = 10;
    localparam int STATUS_HIGH_BIT   = 0;
    localparam int STATUS_SNAP_BIT   = 1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Live base page as decoded by the negotiation logic
    typedef struct packed {
        logic       nextPage;
        logic       ack;
        logic       remoteFault;
        logic       roleForced;
        logic [1:0] pause;
        logic [4:0] selector;
        logic [4:0] nonce;
        logic       t1lAble;
        logic       gigT1Able;
        logic       t1sFullAble;
        logic       fastT1Able;
        logic       energySavingAble;
        logic       highLevelAble;
        logic       highLevelRequest;
        logic       t1sHalfAble;
    } lpbpa_rx_page_s;

    typedef struct packed {
        logic        en;
        lpbpa_idx_t  idx;
        logic [31:0] data;
        logic [3:0]  strb;
    } lpbpa_wr_req_s;

    typedef struct packed {
        logic       en;
        lpbpa_idx_t idx;
    } lpbpa_rd_req_s;

endpackage : lpbpa_pkg

// File: design/lpbpa_axil_slave.sv
`timescale 1ns/100ps
module lpbpa_axil_slave #(
    parameter int ADDR_W = 12
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output wire logic                     s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output wire logic                     s_axi_wready,
    output wire logic [1:0]               s_axi_bresp,
    output wire logic                     s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [ADDR_W-1:0]        s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output wire logic                     s_axi_arready,
    output wire logic [31:0]              s_axi_rdata,
    output wire logic [1:0]               s_axi_rresp,
    output wire logic                     s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    output wire lpbpa_pkg::lpbpa_wr_req_s wrReq,
    input  wire logic                     wrHit,
    output wire lpbpa_pkg::lpbpa_rd_req_s rdReq,
    input  wire logic [31:0]              rdData,
    input  wire logic                     rdHit
);
    import lpbpa_pkg::*;

    logic        awHeld_reg;
    lpbpa_idx_t  awIdx_reg;
    logic        wHeld_reg;
    logic [31:0] wData_reg;
    logic [3:0]  wStrb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    wire         awTake;
    wire         wTake;
    wire         arTake;
    wire         doWrite;

    // No new write is taken while a response waits, so one write at a time
    assign s_axi_awready = ~awHeld_reg & ~bvalid_reg;
    assign s_axi_wready  = ~wHeld_reg & ~bvalid_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign awTake        = s_axi_awvalid & s_axi_awready;
    assign wTake         = s_axi_wvalid & s_axi_wready;
    assign arTake        = s_axi_arvalid & s_axi_arready;
    assign doWrite       = awHeld_reg & wHeld_reg;
    assign wrReq         = '{en: doWrite, idx: awIdx_reg, data: wData_reg, strb: wStrb_reg};
    assign rdReq         = '{en: arTake, idx: lpbpa_idx_t'(s_axi_araddr[ADDR_W-1:2])};
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            awHeld_reg <= 1'b0;
            awIdx_reg  <= '0;
            wHeld_reg  <= 1'b0;
            wData_reg  <= '0;
            wStrb_reg  <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else begin
            if (awTake) begin
                awHeld_reg <= 1'b1;
                awIdx_reg  <= lpbpa_idx_t'(s_axi_awaddr[ADDR_W-1:2]);
            end else if (doWrite) begin
                awHeld_reg <= 1'b0;
            end
            if (wTake) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld_reg <= 1'b0;
            end
            if (doWrite) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wrHit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else if (arTake) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rdHit ? rdData : 32'h0000_0000;
            rresp_reg  <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    default clocking cbS @(posedge clk); endclocking
    default disable iff (rst);

    AST_B_FOLLOWS_BOTH: assert property (
        doWrite |=> s_axi_bvalid && s_axi_bresp == ($past(wrHit) ? RESP_OKAY : RESP_SLVERR))
        else $error("write response did not follow the write");
    AST_R_HOLDS: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");

endmodule : lpbpa_axil_slave

// File: verification/lpbpa_link_partner.sv
`timescale 1ns/100ps
module lpbpa_link_partner (
    input  wire logic                      clk,
    input  wire lpbpa_pkg::lpbpa_rx_page_s pageIn,
    input  wire logic                      pageLoad,
    output lpbpa_pkg::lpbpa_rx_page_s      rxPage
);
    import lpbpa_pkg::*;
    // The far PHY ignores our reset, so a cleared snapshot is always checked against a live page
    always_ff @(posedge clk) begin
        if (pageLoad) begin
            rxPage <= pageIn;
        end
    end
endmodule : lpbpa_link_partner

// File: verification/test_lp_base_page_ability_regs.sv
`timescale 1ns/100ps
module test_lp_base_page_ability_regs;
    import lpbpa_pkg::*;
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    logic [11:0]    awaddr = 12'h000;
    logic [11:0]    araddr = 12'h000;
    logic           awvalid = 1'b0;
    logic           wvalid = 1'b0;
    logic           bready = 1'b0;
    logic           arvalid = 1'b0;
    logic           rready = 1'b0;
    logic [31:0]    wdata = 32'h0;
    logic [3:0]     wstrb = 4'hF;
    logic           awready, wready, bvalid, arready, rvalid, txHighLevel;
    logic [1:0]     bresp, rresp;
    logic [31:0]    rdata, d;
    lpbpa_rx_page_s pageIn = '0;
    logic           pageLoad = 1'b1;
    lpbpa_rx_page_s rxPage, p;
    logic [1:0]     r;
    logic           e;
    int             n_fail = 0;
    int             samples_checked = 0;

    always #10 clk = ~clk;

    lpbpa_link_partner u_partner (.clk(clk), .pageIn(pageIn), .pageLoad(pageLoad), .rxPage(rxPage));

    lpbpa_partner_ability #(.ADDR_W(12)) u_dut (
        .clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rxPage(rxPage), .txHighLevel(txHighLevel)
    );

    function automatic logic [11:0] ba(lpbpa_idx_t i);
        return {i, 2'h0};
    endfunction : ba

    function automatic logic [31:0] midOf(lpbpa_rx_page_s q);
        return {17'h0, q.t1lAble, 6'h0, q.gigT1Able, q.t1sFullAble, q.fastT1Able, q.nonce[4], 4'h0};
    endfunction : midOf

    function automatic logic [31:0] highOf(lpbpa_rx_page_s q);
        return {17'h0, q.energySavingAble, q.highLevelAble, q.highLevelRequest, q.t1sHalfAble,
                11'h0};
    endfunction : highOf

    function automatic logic [31:0] lowOf(lpbpa_rx_page_s q);
        return {16'h0, q.nextPage, q.ack, q.remoteFault, q.roleForced, q.pause, 5'h0, q.selector};
    endfunction : lowOf

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
        end
    endtask : chk

    // Handshakes are judged mid-cycle, so no decision races the edge's own updates
    task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ha, hw, got;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        got = 1'b0;
        while (!got) begin
            @(negedge clk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            got = bvalid;
            rs = bresp;
            @(posedge clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ha, got;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        got = 1'b0;
        while (!got) begin
            @(negedge clk);
            ha = arvalid && arready;
            got = rvalid;
            v = rdata;
            rs = rresp;
            @(posedge clk);
            if (ha) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask : rd

    task automatic rdchk(input logic [11:0] a, input logic [31:0] x, input logic [1:0] xr);
        logic [31:0] v;
        logic [1:0]  rs;
        rd(a, v, rs);
        chk(v, x);
        chk({30'h0, rs}, {30'h0, xr});
    endtask : rdchk

    task automatic setPage(input lpbpa_rx_page_s q);
        @(posedge clk);
        pageIn   <= q;
        pageLoad <= 1'b1;
        @(posedge clk);
        pageLoad <= 1'b0;
        @(posedge clk);
    endtask : setPage

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        void'($urandom(90));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // Live page all ones but nothing snapshot yet
        setPage('1);
        rdchk(ba(IDX_PARTNER_MID), 32'h0, RESP_OKAY);
        rdchk(ba(IDX_PARTNER_HIGH), 32'h0, RESP_OKAY);
        $display("test reset values done");
        for (int i = 0; i < 12; i++) begin
            p = lpbpa_rx_page_s'(24'($urandom));
            if (i == 0) p = '1;
            setPage(p);
            rdchk(ba(IDX_PARTNER_LOW), lowOf(p), RESP_OKAY);
            setPage(i == 0 ? lpbpa_rx_page_s'('0) : lpbpa_rx_page_s'(~p));
            rdchk(ba(IDX_PARTNER_MID), midOf(p), RESP_OKAY);
            rdchk(ba(IDX_PARTNER_HIGH), highOf(p), RESP_OKAY);
        end
        $display("test snapshot done");
        wr(ba(IDX_PARTNER_MID), 32'hFFFFFFFF, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        wr(ba(IDX_PARTNER_HIGH), 32'hFFFFFFFF, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        rdchk(ba(IDX_PARTNER_MID), midOf(p), RESP_OKAY);
        rdchk(ba(IDX_PARTNER_HIGH), highOf(p), RESP_OKAY);
        wr(ba(10'h3FF), 32'hFFFFFFFF, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        rdchk(ba(10'h3FF), 32'h0, RESP_SLVERR);
        $display("test read only done");
        for (int i = 0; i < 16; i++) begin
            p = lpbpa_rx_page_s'(24'($urandom));
            p.highLevelAble = i[1];
            p.highLevelRequest = i[0];
            setPage(p);
            wr(ba(IDX_LOCAL_HIGH), {18'h0, i[3], i[2], 12'h0}, r);
            rd(ba(IDX_LINK_STATUS), d, r);
            e = i[3] & i[1] & (i[2] | i[0]);
            chk({31'h0, d[STATUS_HIGH_BIT]}, {31'h0, e});
            chk({31'h0, d[STATUS_SNAP_BIT]}, 32'h1);
            chk({31'h0, txHighLevel}, {31'h0, e});
        end
        $display("test level resolution done");
        setPage('1);
        rd(ba(IDX_PARTNER_LOW), d, r);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdchk(ba(IDX_PARTNER_MID), 32'h0, RESP_OKAY);
        rdchk(ba(IDX_PARTNER_HIGH), 32'h0, RESP_OKAY);
        chk({31'h0, txHighLevel}, 32'h0);
        rdchk(ba(IDX_LINK_STATUS), 32'h0, RESP_OKAY);
        $display("test mid-run reset done");
        finish_test();
    end
endmodule : test_lp_base_page_ability_regs
